// file: hw/reset_cause_defs.vh
// Constants for the reset-cause status logic: register map, flag
// positions, reset values and program-counter load values.
`ifndef RESET_CAUSE_DEFS_VH
`define RESET_CAUSE_DEFS_VH

// Register byte offsets
`define REG_CAUSE_OFS    8'h00
`define REG_EVENT_OFS    8'h04
`define REG_PC_OFS       8'h08
`define REG_CONFIG_OFS   8'h0c
`define REG_KEPT_OFS     8'h10

// Cause register bit positions
`define BIT_BROWNOUT_N   0
`define BIT_POWERON_N    1
`define BIT_SLEEP_N      2
`define BIT_WATCHDOG_N   3
`define BIT_SWRESET_N    4
`define BIT_STK_UNF      6
`define BIT_STK_FUL      7

// Event register bit positions
`define EV_POR           0
`define EV_BROWNOUT      1
`define EV_SWRESET       2
`define EV_MASTER_CLEAR  3
`define EV_WATCHDOG      4
`define EV_STK_OVF       5
`define EV_STK_UNF       6
`define EV_INT_WAKE      7

// Config register bit positions
`define CFG_STACK_RST_EN 0
`define CFG_HIGH_INT_EN  1
`define CFG_LOW_INT_EN   2
`define CFG_MODE_LSB     3
`define CFG_MODE_MSB     4

// Operating modes
`define MODE_FULL        2'h0
`define MODE_PM_RUN      2'h1
`define MODE_IDLE        2'h2
`define MODE_SLEEP       2'h3

// Program counter values
`define PC_RESET_VEC     21'h000000
`define PC_HIGH_VEC      21'h000008
`define PC_LOW_VEC       21'h000018
`define PC_STEP          21'h000002
`define PC_RESET_VAL     21'h000000

// Flags after power-on: software, watchdog, sleep set; others clear
`define CAUSE_POR_VAL    8'h1c
`define KEPT_RESET_VAL   32'h00000000
`define CONFIG_RESET_VAL 32'h00000001
`define CONFIG_WR_MASK   32'h0000001f

`endif

// file: hw/reset_cause_status.v
// Reset-cause status logic: records why the core reset or woke, sets
// the program counter load, and keeps the flags for software.
// Assumes one clock, AXI4-Lite master; events are one-cycle pulses
// from the core; power-on is signalled by the por_event input.
//
// Operation
// - Power-on and brown-out set flags, PC zero
// - Reset instruction clears software flag only
// - Master-clear in run mode sets timeout flag
// - Master-clear asleep sets timeout, clears power-down
// - Master-clear at full power keeps flags
// - Watchdog reset awake clears timeout flag
// - Enabled overflow resets, sets stack-full flag
// - Enabled underflow resets, sets underflow flag
// - Disabled underflow sets flag without reset
// - Watchdog asleep wakes, PC+2, clears two flags
// - Interrupt wake clears power-down, PC+2
// - Interrupt wake with interrupts enabled loads vector
// - General registers untouched by non-power resets
// - Watchdog wake keeps general registers intact
`timescale 1ns/10ps
`include "reset_cause_defs.vh"

module reset_cause_status
(
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // Core events, one-cycle pulses; then interrupt priority and current PC
   input  wire        por_event,
   input  wire        brownout_event,
   input  wire        swreset_event,
   input  wire        master_clear_input,
   input  wire        watchdog_timer,
   input  wire        stack_overflow_event,
   input  wire        stack_underflow_event,
   input  wire        interrupt_wake_event,
   input  wire        high_int_request,
   input  wire [20:0] current_pc,
   // Core results
   output reg         core_reset,
   output reg         core_wake,
   output reg         pc_load,
   output reg  [20:0] pc_value,
   output reg         clear_kept_regs,
   // Flags for the core
   output reg         software_reset_flag_n,
   output reg         watchdog_expired_flag_n,
   output reg         sleep_entered_flag_n,
   output reg         poweron_flag_n,
   output reg         brownout_flag_n,
   output reg         stack_full_flag,
   output reg         stack_underflow_flag,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   localparam [1:0] RESP_OKAY   = 2'h0;
   localparam [1:0] RESP_SLVERR = 2'h2;

   // Flags after reset match a power-on event
   localparam [7:0] FLAGS_AT_POR = `CAUSE_POR_VAL;

   // Configuration and kept scratch register
   reg  [31:0] config_reg;
   reg  [31:0] kept_reg;
   reg  [7:0]  last_event;
   wire        stack_fault_reset_enable;
   wire        high_priority_global_int_enable;
   wire        low_priority_global_int_enable;
   wire [1:0]  run_mode;
   wire        asleep;

   assign stack_fault_reset_enable        = config_reg[`CFG_STACK_RST_EN];
   assign high_priority_global_int_enable = config_reg[`CFG_HIGH_INT_EN];
   assign low_priority_global_int_enable  = config_reg[`CFG_LOW_INT_EN];
   assign run_mode = config_reg[`CFG_MODE_MSB:`CFG_MODE_LSB];
   // Idle and sleep behave alike for master clear and watchdog
   assign asleep   = (run_mode == `MODE_IDLE) ||
                     (run_mode == `MODE_SLEEP);

   // Write channel capture, either order
   // Each ready lasts one cycle, so a beat is never taken twice;
   // a pending response holds off the next write
   reg         aw_held;
   reg         w_held;
   reg  [7:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   wire        do_write;
   wire        cause_wr;
   wire [7:0]  wr_byte0;

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign cause_wr = do_write && (aw_addr == `REG_CAUSE_OFS) &&
                     w_strb[0];
   assign wr_byte0 = w_data[7:0];

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `REG_CAUSE_OFS || aw_addr == `REG_CONFIG_OFS ||
                aw_addr == `REG_KEPT_OFS)
               s_axi_bresp <= RESP_OKAY;
            else
               s_axi_bresp <= RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Byte-lane merge for the plain registers
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = data[i*8 +: 8];
      end
   endfunction

   // Stack underflow never resets when the enable is low
   wire stk_unf_reset;
   wire stk_ovf_reset;
   wire wdt_reset;
   wire wdt_wake;
   wire any_reset;
   wire any_wake;
   wire vector_wake;

   assign stk_ovf_reset = stack_overflow_event && stack_fault_reset_enable;
   assign stk_unf_reset = stack_underflow_event && stack_fault_reset_enable;
   assign wdt_reset     = watchdog_timer && !asleep;
   assign wdt_wake      = watchdog_timer && asleep;
   assign any_reset     = por_event | brownout_event | swreset_event |
                          master_clear_input | wdt_reset |
                          stk_ovf_reset | stk_unf_reset;
   assign any_wake      = !any_reset && (wdt_wake || interrupt_wake_event);
   // A watchdog wake outranks an interrupt wake for the PC
   assign vector_wake   = interrupt_wake_event && !wdt_wake &&
      (high_priority_global_int_enable || low_priority_global_int_enable);

   // Flag update: software write first, events override it
   // An event in the same cycle as a write wins on the bits it
   // touches; the other bits still take the written value
   reg [7:0] next_flags;
   always @*
   begin
      next_flags = {stack_full_flag, stack_underflow_flag, 1'b0,
                    software_reset_flag_n, watchdog_expired_flag_n,
                    sleep_entered_flag_n, poweron_flag_n,
                    brownout_flag_n};
      if (cause_wr)
         next_flags = {wr_byte0[7:6], 1'b0, wr_byte0[4:0]};
      if (por_event)
         next_flags = `CAUSE_POR_VAL;
      else
      begin
         if (brownout_event)
         begin
            next_flags[`BIT_SWRESET_N]  = 1'b1;
            next_flags[`BIT_WATCHDOG_N] = 1'b1;
            next_flags[`BIT_SLEEP_N]    = 1'b1;
            next_flags[`BIT_BROWNOUT_N] = 1'b0;
         end
         if (swreset_event)
            next_flags[`BIT_SWRESET_N] = 1'b0;
         if (master_clear_input && run_mode != `MODE_FULL)
            next_flags[`BIT_WATCHDOG_N] = 1'b1;
         if (master_clear_input && asleep)
            next_flags[`BIT_SLEEP_N] = 1'b0;
         // Timeout flag clears whether the watchdog resets or wakes
         if (watchdog_timer)
            next_flags[`BIT_WATCHDOG_N] = 1'b0;
         if (wdt_wake)
            next_flags[`BIT_SLEEP_N] = 1'b0;
         if (interrupt_wake_event)
            next_flags[`BIT_SLEEP_N] = 1'b0;
         if (stk_ovf_reset)
            next_flags[`BIT_STK_FUL] = 1'b1;
         // Set even when the enable is low and no reset follows
         if (stack_underflow_event)
            next_flags[`BIT_STK_UNF] = 1'b1;
      end
   end

   // Event outputs and flags
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stack_full_flag         <= FLAGS_AT_POR[`BIT_STK_FUL];
         stack_underflow_flag    <= FLAGS_AT_POR[`BIT_STK_UNF];
         software_reset_flag_n   <= FLAGS_AT_POR[`BIT_SWRESET_N];
         watchdog_expired_flag_n <= FLAGS_AT_POR[`BIT_WATCHDOG_N];
         sleep_entered_flag_n    <= FLAGS_AT_POR[`BIT_SLEEP_N];
         poweron_flag_n          <= FLAGS_AT_POR[`BIT_POWERON_N];
         brownout_flag_n         <= FLAGS_AT_POR[`BIT_BROWNOUT_N];
         core_reset      <= 1'b0;
         core_wake       <= 1'b0;
         pc_load         <= 1'b0;
         pc_value        <= `PC_RESET_VAL;
         clear_kept_regs <= 1'b0;
         last_event      <= 8'h00;
         config_reg      <= `CONFIG_RESET_VAL;
         kept_reg        <= `KEPT_RESET_VAL;
      end
      else
      begin
         stack_full_flag         <= next_flags[`BIT_STK_FUL];
         stack_underflow_flag    <= next_flags[`BIT_STK_UNF];
         software_reset_flag_n   <= next_flags[`BIT_SWRESET_N];
         watchdog_expired_flag_n <= next_flags[`BIT_WATCHDOG_N];
         sleep_entered_flag_n    <= next_flags[`BIT_SLEEP_N];
         poweron_flag_n          <= next_flags[`BIT_POWERON_N];
         brownout_flag_n         <= next_flags[`BIT_BROWNOUT_N];
         core_reset      <= any_reset;
         core_wake       <= any_wake;
         pc_load         <= any_reset | any_wake;
         // Only power-on wipes the kept registers
         clear_kept_regs <= por_event;
         // pc_value holds between events; the core takes it on pc_load
         if (any_reset)
            pc_value <= `PC_RESET_VEC;
         else if (vector_wake)
            pc_value <= high_int_request ? `PC_HIGH_VEC :
                        `PC_LOW_VEC;
         else if (any_wake)
            pc_value <= current_pc + `PC_STEP;
         // Snapshot of the events that moved the PC or the flags
         if (any_reset | any_wake | stack_underflow_event)
            last_event <= {interrupt_wake_event, stack_underflow_event,
                           stack_overflow_event, watchdog_timer,
                           master_clear_input, swreset_event,
                           brownout_event, por_event};
         if (por_event)
            kept_reg <= `KEPT_RESET_VAL;
         else if (do_write && aw_addr == `REG_KEPT_OFS)
            kept_reg <= merge(kept_reg, w_data, w_strb);
         // Unused config bits are not stored and read back as zero
         if (do_write && aw_addr == `REG_CONFIG_OFS)
            config_reg <= merge(config_reg, w_data, w_strb) &
                          `CONFIG_WR_MASK;
      end
   end

   // Read channel, answer one cycle after address
   // Read data is a snapshot; flags may move while rvalid waits
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                          s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr == `REG_CAUSE_OFS)
               s_axi_rdata <= {24'h000000, stack_full_flag,
                  stack_underflow_flag, 1'b0, software_reset_flag_n,
                  watchdog_expired_flag_n, sleep_entered_flag_n,
                  poweron_flag_n, brownout_flag_n};
            else if (s_axi_araddr == `REG_EVENT_OFS)
               s_axi_rdata <= {24'h000000, last_event};
            else if (s_axi_araddr == `REG_PC_OFS)
               s_axi_rdata <= {11'h000, pc_value};
            else if (s_axi_araddr == `REG_CONFIG_OFS)
               s_axi_rdata <= config_reg;
            else if (s_axi_araddr == `REG_KEPT_OFS)
               s_axi_rdata <= kept_reg;
            else
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= RESP_SLVERR;
            end
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // reset_cause_status

// file: bench/reset_cause_status_sva.sv
// Checker for reset_cause_status: flag, pulse and PC relations.
// Bound to the design; sees its ports only, one clock domain.
`timescale 1ns/10ps
module reset_cause_status_sva
(
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Events
   input wire        por_event,
   input wire        brownout_event,
   input wire        swreset_event,
   input wire        master_clear_input,
   input wire        watchdog_timer,
   input wire        stack_overflow_event,
   input wire        stack_underflow_event,
   input wire        interrupt_wake_event,
   // Results
   input wire        core_reset,
   input wire        core_wake,
   input wire        pc_load,
   input wire [20:0] pc_value,
   input wire        clear_kept_regs,
   input wire        s_axi_bvalid,
   // Flags
   input wire        software_reset_flag_n,
   input wire        watchdog_expired_flag_n,
   input wire        sleep_entered_flag_n,
   input wire        poweron_flag_n,
   input wire        brownout_flag_n,
   input wire        stack_full_flag,
   input wire        stack_underflow_flag
);
   wire [7:0] ev;
   wire [7:0] fl;
   assign ev = {interrupt_wake_event, stack_underflow_event,
      stack_overflow_event, watchdog_timer, master_clear_input,
      swreset_event, brownout_event, por_event};
   // Same layout as the cause register
   assign fl = {stack_full_flag, stack_underflow_flag, 1'b0,
      software_reset_flag_n, watchdog_expired_flag_n,
      sleep_entered_flag_n, poweron_flag_n, brownout_flag_n};
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_por_flags:
      assert property (por_event |=> fl == 8'h1c && core_reset)
      else $error("power-on flags wrong");
   a_swreset_clear:
      assert property (ev == 8'h04 |=> fl == ($past(fl) & 8'hef) && core_reset)
      else $error("reset instruction flags wrong");
   a_master_clear_hold:
      assert property (ev == 8'h08 |=> core_reset &&
         (fl & 8'hd3) == ($past(fl) & 8'hd3))
      else $error("master clear flags wrong");
   a_watchdog_reset:
      assert property (ev == 8'h10 ##1 core_reset |->
         fl == ($past(fl) & 8'hf7))
      else $error("watchdog reset flags wrong");
   a_watchdog_wake:
      assert property (ev == 8'h10 ##1 !core_reset |-> core_wake &&
         !clear_kept_regs && fl == ($past(fl) & 8'hf3))
      else $error("watchdog wake flags wrong");
   a_ovf_full:
      assert property (ev == 8'h20 ##1 core_reset |->
         fl == ($past(fl) | 8'h80))
      else $error("overflow flag wrong");
   a_unf_set:
      assert property (ev == 8'h40 |=> fl == ($past(fl) | 8'h40))
      else $error("underflow flag wrong");
   a_int_wake:
      assert property (ev == 8'h80 ##1 core_wake |->
         !core_reset && fl == ($past(fl) & 8'hfb))
      else $error("interrupt wake flags wrong");
   a_reset_pc:
      assert property (core_reset |-> pc_load && pc_value == 21'h0 &&
         !core_wake)
      else $error("reset pc wrong");
   a_kept_por:
      assert property (clear_kept_regs == $past(por_event))
      else $error("kept clear wrong");
   a_flags_hold:
      assert property (ev == 8'h00 ##1 !s_axi_bvalid |-> $stable(fl))
      else $error("flags moved without cause");
endmodule // reset_cause_status_sva

bind reset_cause_status reset_cause_status_sva chk (.*);

// file: bench/tb.sv
// Testbench for reset_cause_status: random events over random flag
// and mode states, checked by a model. Needs design and checker.
`timescale 1ns/10ps
module tb;
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [7:0]  ev = 8'h00;
   reg         high_int_request = 1'b0;
   reg  [20:0] current_pc = 21'h0;
   reg  [7:0]  s_axi_awaddr = 8'h00;
   reg         s_axi_awvalid = 1'b0;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'h0;
   reg         s_axi_wvalid = 1'b0;
   reg         s_axi_bready = 1'b0;
   reg  [7:0]  s_axi_araddr = 8'h00;
   reg         s_axi_arvalid = 1'b0;
   reg         s_axi_rready = 1'b0;
   wire        por_event, brownout_event, swreset_event, master_clear_input;
   wire        watchdog_timer, stack_overflow_event;
   wire        stack_underflow_event, interrupt_wake_event;
   wire        core_reset, core_wake, pc_load, clear_kept_regs;
   wire [20:0] pc_value;
   wire        software_reset_flag_n, watchdog_expired_flag_n;
   wire        sleep_entered_flag_n, poweron_flag_n, brownout_flag_n;
   wire        stack_full_flag, stack_underflow_flag;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire        s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0]  fl;
   int         error_cnt = 0;
   int         comparisons = 0;
   int         i;
   reg  [7:0]  c, e;
   reg  [4:0]  g;
   reg  [20:0] pc;
   reg         hi;
   reg  [31:0] d, k, s;
   reg  [1:0]  r;
   reg  [30:0] x;

   assign {interrupt_wake_event, stack_underflow_event, stack_overflow_event,
      watchdog_timer, master_clear_input, swreset_event, brownout_event,
      por_event} = ev;
   assign fl = {stack_full_flag, stack_underflow_flag, 1'b0,
      software_reset_flag_n, watchdog_expired_flag_n,
      sleep_entered_flag_n, poweron_flag_n, brownout_flag_n};

   always #20 aclk = ~aclk;

   reset_cause_status dut (.*);

   task automatic chk(input string nm, input [39:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task results;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input [7:0] a, input [31:0] v, input [3:0] b,
                     output [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= b;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
   endtask

   task automatic rd(input [7:0] a, output [31:0] v, output [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      resp = s_axi_rresp;
   endtask

   // Returns {reset, wake, pc, flags}; mode in g[4:3], enables g[2:0]
   function automatic [30:0] model(input [7:0] f0, ee, input [4:0] cf,
                                   input [20:0] p0, input h);
      reg [7:0]  f;
      reg        rs, wk;
      reg [20:0] p;
      f = f0;
      rs = |ee[3:0];
      wk = 1'b0;
      p = 21'h0;
      if (ee[0])
         f = 8'h1c;
      else if (ee[1])
         f = (f0 & 8'hc2) | 8'h1c;
      else if (ee[2])
         f[4] = 1'b0;
      else if (ee[3])
      begin
         f[3] = f[3] | (cf[4:3] != 2'h0);
         f[2] = f[2] & ~cf[4];
      end
      else if (ee[4])
      begin
         f[3:2] = {1'b0, f[2] & ~cf[4]};
         rs = ~cf[4];
         wk = cf[4];
      end
      else if (ee[5] | ee[6])
      begin
         f[7:6] = f[7:6] | {ee[5], ee[6]};
         rs = cf[0];
      end
      else if (ee[7])
      begin
         f[2] = 1'b0;
         wk = 1'b1;
      end
      if (wk)
         p = (ee[7] & |cf[2:1]) ? (h ? 21'h8 : 21'h18) : p0 + 21'h2;
      return {rs, wk, p, f};
   endfunction

   initial
   begin
      #800000;
      error_cnt++;
      results;
   end

   initial
   begin
      s = $urandom(32'ha0c7);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      wr(8'h04, 32'hffffffff, 4'hf, r);
      chk("ro write resp", r, 2'h2);
      rd(8'h00, d, r);
      chk("cause after reset", d, 32'h1c);
      rd(8'h20, d, r);
      chk("unmapped read", {r, d}, {2'h2, 32'h0});
      for (i = 0; i < 200; i++)
      begin
         e = 8'h01 << ($urandom % 8);
         // Power-on must win over a coincident reset instruction
         if (i == 0)
            e = 8'h05;
         g = 5'($urandom);
         g[0] = g[0] | e[5];
         g[4] = g[4] | e[7];
         c = 8'($urandom) & 8'hdf;
         k = $urandom;
         pc = 21'($urandom);
         hi = 1'($urandom);
         wr(8'h0c, {27'h0, g}, 4'hf, r);
         wr(8'h10, k, 4'hf, r);
         chk("kept write resp", r, 2'h0);
         wr(8'h00, {24'h0, c}, 4'h1, r);
         rd(8'h00, d, r);
         chk("cause write", {r, d}, {2'h0, 24'h0, c});
         x = model(c, e, g, pc, hi);
         @(posedge aclk);
         ev <= e;
         current_pc <= pc;
         high_int_request <= hi;
         @(posedge aclk);
         ev <= 8'h00;
         @(negedge aclk);
         chk("flags", fl, x[7:0]);
         chk("pulses", {core_reset, core_wake, pc_load},
             {x[30:29], |x[30:29]});
         if (|x[30:29])
            chk("pc", pc_value, x[28:8]);
         chk("kept clear", clear_kept_regs, e[0]);
         if (|x[30:29])
         begin
            rd(8'h08, d, r);
            chk("pc reg", {r, d}, {2'h0, 11'h0, x[28:8]});
         end
         rd(8'h04, d, r);
         chk("event reg", {r, d}, {2'h0, 24'h0, e});
         rd(8'h10, d, r);
         chk("kept", d, e[0] ? 32'h0 : k);
      end
      results;
   end
endmodule // tb
